//--- design/bdc_branch_decode.sv
// instruction decode and cycle accounting: branches, traps, stack, copy, indexed
// assumes fetch bytes arrive in program order, synchronous to clk_sys
`timescale 1ns/1ps
module bdc_branch_decode
  import bdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire bdc_fetch_s fetch,
  input wire logic [7:0] ccIn,
  input wire bdc_alu_s alu,
  output bdc_result_s result,
  output logic resValid,
  output logic nibbleCarry
);
  bdc_core_s cur_ff;
  bdc_core_s nxt_core;

  // branch condition from the low opcode nibble, bit 0 inverts
  function automatic logic condMet(input logic [3:0] code, input logic [7:0] cc);
    logic base;
    base = 1'b1;
    unique case (code[3:1])
      3'h0: base = 1'b1;
      3'h1: base = !(cc[CC_C] | cc[CC_Z]);
      3'h2: base = !cc[CC_C];
      3'h3: base = !cc[CC_Z];
      3'h4: base = !cc[CC_V];
      3'h5: base = !cc[CC_N];
      3'h6: base = !(cc[CC_N] ^ cc[CC_V]);
      3'h7: base = !(cc[CC_Z] | (cc[CC_N] ^ cc[CC_V]));
    endcase
    return base ^ code[0];
  endfunction

  // bytes moved by a stack op: high four mask bits are word registers
  function automatic logic [4:0] stackBytes(input logic [7:0] mask);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 8; i++) begin
      if (mask[i]) begin
        n = n + ((i >= 4) ? 5'h02 : 5'h01);
      end
    end
    return n;
  endfunction

  // copy register code: 2 = 16-bit, 1 = 8-bit, 0 = no register
  function automatic logic [1:0] regWidth(input logic [3:0] code);
    if (code <= 4'h5) begin
      return 2'h2;
    end else if (code >= 4'h8 && code <= 4'hb) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction

  // indexed postbyte extras {cycles, bytes, bad}
  function automatic logic [9:0] idxExtra(input logic [7:0] pb);
    logic [4:0] c;
    logic [3:0] b;
    logic bad;
    c = 5'h01;
    b = 4'h0;
    bad = 1'b0;
    if (pb[7]) begin
      unique case (pb[3:0])
        4'h0, 4'h2: begin
          c = 5'h02;
          bad = pb[4];
        end
        4'h1, 4'h3: c = 5'h03;
        4'h4: c = 5'h00;
        4'h5, 4'h6: c = 5'h01;
        4'h8, 4'hc: b = 4'h1;
        4'h9: begin
          c = 5'h04;
          b = 4'h2;
        end
        4'hb: c = 5'h04;
        4'hd: begin
          c = 5'h05;
          b = 4'h2;
        end
        4'hf: begin
          c = 5'h02;
          b = 4'h2;
          bad = !(pb[4] && pb[6:5] == 2'h0);
        end
        default: bad = 1'b1;
      endcase
      if (pb[4]) begin
        c = c + IND_EXTRA_CYC;
      end
    end
    return {c, b, bad};
  endfunction

  // full decode of one finished instruction
  function automatic bdc_result_s decode(input logic [1:0] pg, input logic [7:0] op,
      input logic [7:0] pb, input logic [15:0] dsp, input logic [15:0] adr,
      input logic [7:0] cc);
    bdc_result_s r;
    logic [9:0] ix;
    logic [1:0] wSrc;
    logic [1:0] wDst;
    r = '0;
    ix = idxExtra(pb);
    wSrc = regWidth(pb[7:4]);
    wDst = regWidth(pb[3:0]);
    r.page = pg;
    r.opcode = op;
    r.post = pb;
    if (op == OP_TRAP) begin
      r.kind = K_TRAP;
      r.cycles = (pg == 2'h0) ? TRAP1_CYC : TRAP23_CYC;
      r.bytes = (pg == 2'h0) ? TRAP1_BYTES : TRAP23_BYTES;
      r.setMaskI = (pg == 2'h0);
      r.setMaskF = (pg == 2'h0);
    end else if (op >= OP_BR_LO && op <= OP_BR_HI) begin
      r.kind = K_BRANCH;
      r.taken = condMet(op[3:0], cc);
      if (pg == 2'h0) begin
        r.bytes = SHORT_BYTES;
        r.cycles = SHORT_CYC;
      end else begin
        r.bytes = LONG_BYTES;
        r.cycles = r.taken ? LONG_TAKEN_CYC : LONG_NOT_CYC;
        r.illegal = (pg != 2'h1) || (op == OP_BR_LO);
        r.taken = r.taken && !r.illegal;
      end
      r.target = adr + {12'h000, r.bytes} + (r.taken ? dsp : 16'h0000);
    end else if (pg != 2'h0) begin
      r.kind = K_OTHER;
    end else if (op >= OP_STK_LO && op <= OP_STK_HI) begin
      r.kind = K_STACK;
      r.bytes = POST_BYTES;
      r.cycles = STK_BASE_CYC + stackBytes(pb);
    end else if (op == OP_COPY) begin
      r.kind = K_COPY;
      r.bytes = POST_BYTES;
      r.cycles = COPY_CYC;
      r.illegal = (wSrc == 2'h0) || (wSrc != wDst);
    end else if (op >= OP_LEA_LO && op <= OP_LEA_HI) begin
      r.kind = K_INDEX;
      r.cycles = LEA_CYC + ix[9:5];
      r.bytes = POST_BYTES + ix[4:1];
      r.illegal = ix[0];
    end else begin
      r.kind = K_OTHER;
      r.illegal = op inside {8'h01, 8'h02, 8'h05, 8'h0b, 8'h14, 8'h15,
                             8'h18, 8'h1b, 8'h38, 8'h3e};
    end
    return r;
  endfunction

  // next-state: byte sequencer and result build
  always_comb begin
    logic fin;
    logic [7:0] pb;
    logic [4:0] nib;
    fin = 1'b0;
    pb = 8'h00;
    nib = 5'h00;
    nxt_core = cur_ff;
    nxt_core.resValid = 1'b0;
    unique case (cur_ff.st)
      S_OPC: begin
        if (fetch.valid) begin
          nxt_core.addr = fetch.addr;
          nxt_core.page = 2'h0;
          nxt_core.opc = fetch.data;
          nxt_core.disp = 16'h0000;
          if (fetch.data == PFX_PAGE2 || fetch.data == PFX_PAGE3) begin
            nxt_core.page = (fetch.data == PFX_PAGE2) ? 2'h1 : 2'h2;
            nxt_core.st = S_PFX;
          end else if (fetch.data >= OP_BR_LO && fetch.data <= OP_BR_HI) begin
            nxt_core.st = S_DLO;
          end else if ((fetch.data >= OP_LEA_LO && fetch.data <= OP_STK_HI)
              || fetch.data == OP_COPY) begin
            nxt_core.st = S_POST;
          end else begin
            fin = 1'b1;
          end
        end
      end
      S_PFX: begin
        if (fetch.valid) begin
          nxt_core.opc = fetch.data;
          if (cur_ff.page == 2'h1 && fetch.data > OP_BR_LO && fetch.data <= OP_BR_HI) begin
            nxt_core.st = S_DHI;
          end else begin
            fin = 1'b1;
          end
        end
      end
      S_DHI: begin
        if (fetch.valid) begin
          nxt_core.disp[15:8] = fetch.data;
          nxt_core.st = S_DLO;
        end
      end
      S_DLO: begin
        if (fetch.valid) begin
          nxt_core.disp[7:0] = fetch.data;
          if (cur_ff.page == 2'h0) begin
            nxt_core.disp[15:8] = {8{fetch.data[7]}};
          end
          fin = 1'b1;
        end
      end
      S_POST: begin
        if (fetch.valid) begin
          pb = fetch.data;
          fin = 1'b1;
        end
      end
      default: nxt_core.st = S_OPC;
    endcase
    if (fin) begin
      nxt_core.st = S_OPC;
      nxt_core.resValid = 1'b1;
      nxt_core.res = decode(nxt_core.page, nxt_core.opc, pb, nxt_core.disp,
                            nxt_core.addr, ccIn);
    end
    // nibble carry from the low four bits of the adder
    nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.cin};
    nxt_core.nibCarry = nib[4];
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_core;
    end
  end

  assign result = cur_ff.res;
  assign resValid = cur_ff.resValid;
  assign nibbleCarry = cur_ff.nibCarry;

  // checks on the sequencer, the decoded results and the nibble carry
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_short_cond_seq: assert property (
    (cur_ff.st == S_OPC && fetch.valid && fetch.data > 8'h21 && fetch.data <= OP_BR_HI)
    |=> cur_ff.st == S_DLO) else $error("short branch not decoded");
  a_short_count: assert property (
    resValid && result.kind == K_BRANCH && result.page == 2'h0
    |-> result.bytes == 4'h2 && result.cycles == 5'h03) else $error("short count");
  a_long_opcode: assert property (
    resValid && result.kind == K_BRANCH && result.page == 2'h1 && !result.illegal
    |-> result.opcode > 8'h20 && $past(cur_ff.st, 2) == S_DHI) else $error("long form");
  a_long_count: assert property (
    resValid && result.kind == K_BRANCH && result.page == 2'h1 && !result.illegal
    |-> result.bytes == 4'h4 && result.cycles == (result.taken ? 5'h06 : 5'h05))
    else $error("long count");
  a_stack_cycles: assert property (
    resValid && result.kind == K_STACK
    |-> result.cycles == 5'h05 + 5'($countones(result.post[3:0]))
        + 5'(2 * $countones(result.post[7:4]))) else $error("stack cycles");
  a_trap_masks: assert property (
    resValid && result.kind == K_TRAP && result.page == 2'h0
    |-> result.setMaskI && result.setMaskF) else $error("primary trap masks");
  a_trap_keep: assert property (
    resValid && result.kind == K_TRAP && result.page != 2'h0
    |-> !result.setMaskI && !result.setMaskF) else $error("trap masks changed");
  a_unused_flag: assert property (
    cur_ff.st == S_OPC && fetch.valid && fetch.data == 8'h01
    |=> resValid && result.illegal) else $error("unused opcode not flagged");
  a_copy_width: assert property (
    resValid && result.kind == K_COPY && !result.illegal
    |-> (result.post[7:4] <= 4'h5) == (result.post[3:0] <= 4'h5)) else $error("copy width");
  a_copy_wide: assert property (
    resValid && result.kind == K_COPY && result.post[7:4] <= 4'h5
    && result.post[3:0] <= 4'h5 |-> !result.illegal) else $error("wide copy refused");
  a_index_extra: assert property (
    resValid && result.kind == K_INDEX && result.post == 8'h99
    |-> result.cycles == 5'h0b && result.bytes == 4'h4) else $error("indexed extras");
  a_nibble_carry: assert property (
    ##1 nibbleCarry == ($past(alu.a[3:0]) + $past(alu.b[3:0]) + $past(alu.cin) > 15))
    else $error("nibble carry");
  a_page_prefix: assert property (
    cur_ff.st == S_OPC && fetch.valid && fetch.data == 8'h11
    |=> cur_ff.st == S_PFX && cur_ff.page == 2'h2) else $error("page three prefix");
  a_branch_target: assert property (
    resValid && result.kind == K_BRANCH
    |-> result.target == cur_ff.addr + {12'h000, result.bytes}
        + (result.taken ? cur_ff.disp : 16'h0000)) else $error("branch target");
endmodule

//--- design/bdc_pkg.sv
// constants, types and result layout for the branch decode and cycle timing slice
// assumes one core clock; no software-visible registers
package bdc_pkg;
  // opcode page prefixes and opcode groups
  localparam logic [7:0] PFX_PAGE2 = 8'h10;
  localparam logic [7:0] PFX_PAGE3 = 8'h11;
  localparam logic [7:0] OP_TRAP = 8'h3f;
  localparam logic [7:0] OP_COPY = 8'h1f;
  localparam logic [7:0] OP_BR_LO = 8'h20;
  localparam logic [7:0] OP_BR_HI = 8'h2f;
  localparam logic [7:0] OP_LEA_LO = 8'h30;
  localparam logic [7:0] OP_LEA_HI = 8'h33;
  localparam logic [7:0] OP_STK_LO = 8'h34;
  localparam logic [7:0] OP_STK_HI = 8'h37;
  // byte and cycle counts
  localparam logic [3:0] SHORT_BYTES = 4'h2;
  localparam logic [4:0] SHORT_CYC = 5'h03;
  localparam logic [3:0] LONG_BYTES = 4'h4;
  localparam logic [4:0] LONG_TAKEN_CYC = 5'h06;
  localparam logic [4:0] LONG_NOT_CYC = 5'h05;
  localparam logic [4:0] STK_BASE_CYC = 5'h05;
  localparam logic [3:0] POST_BYTES = 4'h2;
  localparam logic [4:0] COPY_CYC = 5'h06;
  localparam logic [4:0] TRAP1_CYC = 5'h13;
  localparam logic [4:0] TRAP23_CYC = 5'h14;
  localparam logic [3:0] TRAP1_BYTES = 4'h1;
  localparam logic [3:0] TRAP23_BYTES = 4'h2;
  localparam logic [4:0] LEA_CYC = 5'h04;
  localparam logic [4:0] IND_EXTRA_CYC = 5'h03;
  // condition code bit positions
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;

  typedef enum logic [2:0] {
    K_OTHER = 3'h0, K_BRANCH = 3'h1, K_STACK = 3'h2,
    K_COPY = 3'h3, K_TRAP = 3'h4, K_INDEX = 3'h5
  } bdc_kind_e;

  // gray along opcode -> prefix -> displacement high -> displacement low
  typedef enum logic [2:0] {
    S_OPC = 3'h0, S_PFX = 3'h1, S_DHI = 3'h3, S_DLO = 3'h2, S_POST = 3'h6
  } bdc_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [15:0] addr;
  } bdc_fetch_s;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
  } bdc_alu_s;

  typedef struct packed {
    bdc_kind_e kind;
    logic illegal;
    logic [1:0] page;
    logic [7:0] opcode;
    logic [7:0] post;
    logic [3:0] bytes;
    logic [4:0] cycles;
    logic taken;
    logic [15:0] target;
    logic setMaskI;
    logic setMaskF;
  } bdc_result_s;

  typedef struct packed {
    bdc_state_e st;
    logic [1:0] page;
    logic [7:0] opc;
    logic [15:0] addr;
    logic [15:0] disp;
    logic resValid;
    bdc_result_s res;
    logic nibCarry;
  } bdc_core_s;
endpackage

//--- verification/bdc_branch_decode_tb.sv
// self-checking bench for the decode and cycle accounting slice
// assumes the fetch model in front of the decoder; results checked from a queue
`timescale 1ns/1ps
module bdc_branch_decode_tb;
  import bdc_pkg::*;
  localparam int RW = $bits(bdc_result_s);
  typedef struct packed {bdc_result_s e; bdc_result_s m;} bdc_note_s;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pushValid = 1'b0;
  logic [7:0] pushData = 8'h00;
  logic [15:0] pushAddr = 16'h0000;
  logic [7:0] ccIn = 8'h00;
  bdc_alu_s alu = '0;
  bdc_fetch_s fetch;
  bdc_result_s result;
  logic resValid;
  logic nibbleCarry;
  int n_errors = 0;
  int num_checks = 0;
  integer seed = 75838;
  bdc_note_s expQ[$];
  bdc_note_s nt;
  bdc_result_s mBr, mTrap, mIll, mCopy, mIdx;

  always #4 clk_sys = ~clk_sys;

  bdc_fetch_model bdc_fetch_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .pushValid(pushValid),
    .pushData(pushData), .pushAddr(pushAddr), .fetch(fetch));
  bdc_branch_decode bdc_branch_decode_i (.clk_sys(clk_sys), .rst_n(rst_n), .fetch(fetch),
    .ccIn(ccIn), .alu(alu), .result(result), .resValid(resValid), .nibbleCarry(nibbleCarry));

  task automatic check(input logic [RW-1:0] seen, input logic [RW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic bdc_result_s fill(input bdc_kind_e k, input logic il, input logic [1:0] pg,
      input logic [3:0] by, input logic [4:0] cy, input logic tk, input logic [15:0] tg,
      input logic mi, input logic mf);
    fill = '{kind: k, illegal: il, page: pg, opcode: 8'h00, post: 8'h00, bytes: by,
      cycles: cy, taken: tk, target: tg, setMaskI: mi, setMaskF: mf};
  endfunction

  // branch condition from opcode low nibble: odd codes invert the even one
  function automatic logic cond(input logic [3:0] n, input logic [7:0] cc);
    logic c, v, z, b;
    c = cc[0];
    v = cc[1];
    z = cc[2];
    case (n[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !(c | z);
      3'h2: b = !c;
      3'h3: b = !z;
      3'h4: b = !v;
      3'h5: b = !cc[3];
      3'h6: b = !(cc[3] ^ v);
      default: b = !(z | (cc[3] ^ v));
    endcase
    cond = b ^ n[0];
  endfunction

  // one instruction, one byte per edge; cc moves with the first byte
  task automatic send(input logic [7:0] q[$], input logic [15:0] a, input logic [7:0] cc,
      input bdc_result_s e, input bdc_result_s m, input bit gap);
    expQ.push_back('{e: e, m: m});
    for (int i = 0; i < q.size(); i++) begin
      @(posedge clk_sys);
      pushValid <= 1'b1;
      pushData <= q[i];
      pushAddr <= a + 16'(i);
      if (i == 0) ccIn <= cc;
    end
    if (gap) begin
      @(posedge clk_sys);
      pushValid <= 1'b0;
    end
  endtask

  // results popped in order whenever a decode finishes
  always @(negedge clk_sys) begin
    if (rst_n === 1'b1 && resValid === 1'b1) begin
      if (expQ.size() == 0) begin
        n_errors++;
        $display("[ERR] %0t result with nothing expected", $time);
      end else begin
        nt = expQ.pop_front();
        check(result & nt.m, nt.e & nt.m);
      end
    end
  end

  initial begin
    logic [7:0] bq[$];
    logic [7:0] cc, d8, op, pb;
    logic [15:0] a, d16, tg;
    logic tk, ec, ep;
    logic [7:0] illList[10];
    int nb;
    illList = '{8'h01, 8'h02, 8'h05, 8'h0b, 8'h14, 8'h15, 8'h18, 8'h1b, 8'h38, 8'h3e};
    mBr = fill(bdc_kind_e'(3'h7), 1, 2'h3, 4'hf, 5'h1f, 1, 16'hffff, 0, 0);
    mTrap = fill(bdc_kind_e'(3'h7), 1, 2'h3, 4'hf, 5'h1f, 0, 16'h0, 1, 1);
    mIll = fill(bdc_kind_e'(3'h0), 1, 2'h0, 4'h0, 5'h00, 0, 16'h0, 0, 0);
    mCopy = fill(bdc_kind_e'(3'h7), 1, 2'h0, 4'hf, 5'h1f, 0, 16'h0, 0, 0);
    mIdx = fill(bdc_kind_e'(3'h0), 1, 2'h0, 4'hf, 5'h1f, 0, 16'h0, 0, 0);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // every condition short, all but code 0 long, random flags and offsets
    for (int r = 0; r < 4; r++) begin
      for (int n = 0; n < 16; n++) begin
        op = 8'h20 | 8'(n);
        cc = $random(seed);
        a = $random(seed);
        d8 = $random(seed);
        tk = cond(n[3:0], cc);
        tg = tk ? a + 16'h2 + {{8{d8[7]}}, d8} : a + 16'h2;
        bq = {op, d8};
        send(bq, a, cc, fill(K_BRANCH, 0, 2'h0, 4'h2, 5'h03, tk, tg, 0, 0), mBr, 1);
        if (n == 0) continue;
        d16 = $random(seed);
        tg = tk ? a + 16'h4 + d16 : a + 16'h4;
        bq = {PFX_PAGE2, op, d16[15:8], d16[7:0]};
        send(bq, a, cc, fill(K_BRANCH, 0, 2'h1, 4'h4, tk ? 5'h06 : 5'h05, tk, tg, 0, 0),
          mBr, 1);
      end
    end
    // three traps and their mask effects
    bq = {OP_TRAP};
    send(bq, 16'h0400, 8'h00, fill(K_TRAP, 0, 2'h0, 4'h1, 5'h13, 0, 0, 1, 1), mTrap, 1);
    bq = {PFX_PAGE2, OP_TRAP};
    send(bq, 16'h0410, 8'h00, fill(K_TRAP, 0, 2'h1, 4'h2, 5'h14, 0, 0, 0, 0), mTrap, 1);
    bq = {PFX_PAGE3, OP_TRAP};
    send(bq, 16'h0420, 8'h00, fill(K_TRAP, 0, 2'h2, 4'h2, 5'h14, 0, 0, 0, 0), mTrap, 1);
    // stack ops: five plus one per byte moved
    for (int r = 0; r < 8; r++) begin
      pb = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($random(seed));
      nb = pb[0] + pb[1] + pb[2] + pb[3] + 2 * (pb[4] + pb[5] + pb[6] + pb[7]);
      bq = {OP_STK_LO | 8'(r % 4), pb};
      send(bq, 16'h0500, 8'h00, fill(K_STACK, 0, 2'h0, 4'h2, 5'(5 + nb), 0, 0, 0, 0),
        mCopy, 1);
    end
    // register copy over every postbyte, back to back
    for (int p = 0; p < 256; p++) begin
      pb = 8'(p);
      tk = (pb[7:4] < 4'h6 && pb[3:0] < 4'h6) || (pb[7:6] == 2'h2 && pb[3:2] == 2'h2);
      bq = {OP_COPY, pb};
      send(bq, 16'h0600, 8'h00, fill(K_COPY, !tk, 2'h0, 4'h2, 5'h06, 0, 0, 0, 0),
        tk ? mCopy : mIll, 0);
    end
    // unused opcodes flagged
    for (int i = 0; i < 10; i++) begin
      bq = {illList[i]};
      send(bq, 16'h0700, 8'h00, fill(K_OTHER, 1, 2'h0, 4'h0, 5'h00, 0, 0, 0, 0), mIll, 0);
    end
    // indexed: plain, 8-bit offset, indirect
    bq = {OP_LEA_LO, 8'h84};
    send(bq, 16'h0800, 8'h00, fill(K_INDEX, 0, 2'h0, 4'h2, 5'h04, 0, 0, 0, 0), mIdx, 1);
    bq = {OP_LEA_LO, 8'h88};
    send(bq, 16'h0810, 8'h00, fill(K_INDEX, 0, 2'h0, 4'h3, 5'h05, 0, 0, 0, 0), mIdx, 1);
    bq = {OP_LEA_LO, 8'h94};
    send(bq, 16'h0820, 8'h00, fill(K_INDEX, 0, 2'h0, 4'h2, 5'h07, 0, 0, 0, 0), mIdx, 1);
    // nibble carry one cycle after random operands
    ep = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      d8 = $random(seed);
      cc = $random(seed);
      tk = $random(seed);
      alu <= '{a: d8, b: cc, cin: tk};
      ec = ({1'b0, d8[3:0]} + {1'b0, cc[3:0]} + {4'h0, tk}) > 5'h0f;
      @(negedge clk_sys);
      if (i > 0) check(RW'(nibbleCarry), RW'(ep));
      ep = ec;
    end
    for (int i = 0; i < 50 && expQ.size() > 0; i++) @(posedge clk_sys);
    if (expQ.size() > 0) begin
      n_errors++;
      $display("[ERR] %0t results missing", $time);
    end
    wrap_up();
  end
endmodule

//--- verification/bdc_fetch_model.sv
// fetch unit model: hands instruction bytes to the decoder in program order
// assumes the bench pushes one byte per clk_sys edge; bytes pass through one register
`timescale 1ns/1ps
module bdc_fetch_model
  import bdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pushValid,
  input wire logic [7:0] pushData,
  input wire logic [15:0] pushAddr,
  output bdc_fetch_s fetch
);
  // idle cycles scramble data and address so stale bytes cannot pass as real ones
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch <= '0;
    end else if (pushValid) begin
      fetch <= '{valid: 1'b1, data: pushData, addr: pushAddr};
    end else begin
      fetch <= '{valid: 1'b0, data: ~fetch.data, addr: ~fetch.addr};
    end
  end
endmodule
